/* File: rtl/sep_buf2.sv */
`include "sep_params.svh"

module sep_buf2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);

	logic [WIDTH-1:0] mem_ff [2];
	logic             wptr_ff;
	logic             rptr_ff;
	logic [1:0]       cnt_ff;
	logic             nxt_wptr;
	logic             nxt_rptr;
	logic [1:0]       nxt_cnt;
	logic             push;
	logic             pop;

	assign o_in_ready  = (cnt_ff != 2'h2);
	assign o_out_valid = (cnt_ff != 2'h0);
	assign o_out_data  = mem_ff[rptr_ff];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		nxt_wptr = wptr_ff ^ push;
		nxt_rptr = rptr_ff ^ pop;
		nxt_cnt  = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 2'h1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 2'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			wptr_ff <= 1'b0;
			rptr_ff <= 1'b0;
			cnt_ff  <= 2'h0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff  <= nxt_cnt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wptr_ff] <= i_in_data;
		end
	end

	property p_buf_bound;
		@(posedge i_clk) disable iff (!i_resetn)
		cnt_ff <= 2'h2;
	endproperty
	a_buf_bound: assert property (p_buf_bound)
		else $error("two-entry buffer count out of range");

endmodule : sep_buf2

/* File: rtl/sep_eeprom.sv */
`include "sep_params.svh"

module sep_eeprom (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda_out,
	output logic      o_sda_oe,
	output logic      o_busy
);

	localparam logic [7:0] WR_CYCLES = 8'(`SEP_WR_CYCLES);

	sep_pkg::sep_byte_t  mem_ff [16];
	sep_pkg::sep_state_e state_ff;
	sep_pkg::sep_state_e nxt_state;
	logic [2:0]          scl_ff;
	logic [2:0]          sda_ff;
	logic [3:0]          cnt_ff;
	logic [3:0]          nxt_cnt;
	sep_pkg::sep_byte_t  sr_ff;
	sep_pkg::sep_byte_t  nxt_sr;
	sep_pkg::sep_byte_t  tx_ff;
	sep_pkg::sep_byte_t  nxt_tx;
	sep_pkg::sep_byte_t  wbuf_ff;
	sep_pkg::sep_byte_t  nxt_wbuf;
	sep_pkg::sep_addr_t  ptr_ff;
	sep_pkg::sep_addr_t  nxt_ptr;
	logic                wvld_ff;
	logic                nxt_wvld;
	logic                oe_ff;
	logic                nxt_oe;
	logic                busy_ff;
	logic                nxt_busy;
	logic [7:0]          tmr_ff;
	logic [7:0]          nxt_tmr;
	logic                mem_we;
	logic                fetch;
	logic                fetch_ok;
	logic                load;
	logic                buf_valid;
	sep_pkg::sep_byte_t  buf_data;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_cond;
	logic                stop_cond;
	logic                code_hit;

	function automatic sep_pkg::sep_byte_t shl(input sep_pkg::sep_byte_t b,
		input logic in_bit);
		shl = {b[6:0], in_bit};
	endfunction : shl

	// Bit 0 of each chain is the first synchroniser stage
	assign scl_rise   = scl_ff[1] & ~scl_ff[2];
	assign scl_fall   = ~scl_ff[1] & scl_ff[2];
	assign start_cond = scl_ff[1] & scl_ff[2] & sda_ff[2] & ~sda_ff[1];
	assign stop_cond  = scl_ff[1] & scl_ff[2] & ~sda_ff[2] & sda_ff[1];
	assign code_hit   = (sr_ff[`SEP_CODE_MSB:`SEP_CODE_LSB] ==
		`SEP_DEV_CODE);

	assign o_sda_out = 1'b0;
	assign o_sda_oe  = oe_ff;
	assign o_busy    = busy_ff;

	sep_buf2 #(
		.WIDTH (8)
	) u_buf (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (fetch),
		.o_in_ready  (fetch_ok),
		.i_in_data   (mem_ff[ptr_ff]),
		.o_out_valid (buf_valid),
		.i_out_ready (load),
		.o_out_data  (buf_data)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_sr    = sr_ff;
		nxt_tx    = tx_ff;
		nxt_wbuf  = wbuf_ff;
		nxt_ptr   = ptr_ff;
		nxt_wvld  = wvld_ff;
		nxt_oe    = oe_ff;
		nxt_busy  = busy_ff;
		nxt_tmr   = tmr_ff;
		mem_we    = 1'b0;
		fetch     = 1'b0;
		load      = 1'b0;
		if (busy_ff) begin
			nxt_tmr = tmr_ff - 8'h01;
			if (tmr_ff == 8'h01) begin
				nxt_busy = 1'b0;
				mem_we   = 1'b1;
			end
		end
		if (stop_cond) begin
			// Commit only a whole byte; anything partial aborts
			// The clock rise of the stop itself counts as one bit
			if (state_ff == sep_pkg::SEP_DATA && cnt_ff <= 4'h1 && wvld_ff &&
				!busy_ff) begin
				nxt_busy = 1'b1;
				nxt_tmr  = WR_CYCLES;
			end
			nxt_state = sep_pkg::SEP_IDLE;
			nxt_oe    = 1'b0;
			nxt_wvld  = 1'b0;
			nxt_cnt   = 4'h0;
		end else if (start_cond) begin
			// Repeated start drops a pending write, pointer kept
			nxt_state = sep_pkg::SEP_CTRL;
			nxt_oe    = 1'b0;
			nxt_wvld  = 1'b0;
			nxt_cnt   = 4'h0;
		end else begin
			case (state_ff)
				sep_pkg::SEP_CTRL, sep_pkg::SEP_ADDR, sep_pkg::SEP_DATA: begin
					if (scl_rise && cnt_ff != `SEP_BYTE_BITS) begin
						nxt_sr  = shl(sr_ff, sda_ff[1]);
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == `SEP_BYTE_BITS) begin
						nxt_cnt = 4'h0;
						if (state_ff == sep_pkg::SEP_CTRL) begin
							if (code_hit && !busy_ff) begin
								nxt_oe = 1'b1;
								if (sr_ff[`SEP_RW_BIT]) begin
									nxt_state = sep_pkg::SEP_ACK_RD;
									fetch     = 1'b1;
								end else begin
									nxt_state = sep_pkg::SEP_ACK_CTRL;
								end
							end else begin
								nxt_state = sep_pkg::SEP_IDLE;
							end
						end else if (state_ff == sep_pkg::SEP_ADDR) begin
							nxt_ptr   = sr_ff[3:0];
							nxt_oe    = 1'b1;
							nxt_state = sep_pkg::SEP_ACK_ADDR;
						end else begin
							nxt_wbuf  = sr_ff;
							nxt_wvld  = 1'b1;
							nxt_oe    = 1'b1;
							nxt_state = sep_pkg::SEP_ACK_DATA;
						end
					end
				end
				sep_pkg::SEP_ACK_CTRL: begin
					if (scl_fall) begin
						nxt_oe    = 1'b0;
						nxt_state = sep_pkg::SEP_ADDR;
					end
				end
				sep_pkg::SEP_ACK_ADDR, sep_pkg::SEP_ACK_DATA: begin
					if (scl_fall) begin
						nxt_oe    = 1'b0;
						nxt_state = sep_pkg::SEP_DATA;
					end
				end
				sep_pkg::SEP_ACK_RD: begin
					if (scl_fall) begin
						load      = 1'b1;
						nxt_tx    = buf_valid ? buf_data : `SEP_IDLE_BYTE;
						nxt_oe    = ~nxt_tx[7];
						nxt_cnt   = 4'h1;
						nxt_state = sep_pkg::SEP_TX;
					end
				end
				sep_pkg::SEP_TX: begin
					if (scl_fall) begin
						if (cnt_ff == `SEP_BYTE_BITS) begin
							nxt_oe    = 1'b0;
							nxt_cnt   = 4'h0;
							nxt_state = sep_pkg::SEP_MACK;
						end else begin
							nxt_tx  = shl(tx_ff, 1'b1);
							nxt_oe  = ~tx_ff[6];
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				sep_pkg::SEP_MACK: begin
					if (scl_rise) begin
						if (!sda_ff[1]) begin
							nxt_state = sep_pkg::SEP_ACK_RD;
							fetch     = 1'b1;
						end else begin
							nxt_state = sep_pkg::SEP_IDLE;
						end
					end
				end
				default: begin
					nxt_state = state_ff;
				end
			endcase
		end
		if (fetch && fetch_ok) begin
			nxt_ptr = ptr_ff + 4'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			scl_ff   <= 3'h7;
			sda_ff   <= 3'h7;
			state_ff <= sep_pkg::SEP_IDLE;
			cnt_ff   <= 4'h0;
			sr_ff    <= `SEP_BYTE_RST;
			tx_ff    <= `SEP_BYTE_RST;
			wbuf_ff  <= `SEP_BYTE_RST;
			ptr_ff   <= `SEP_PTR_RST;
			wvld_ff  <= 1'b0;
			oe_ff    <= 1'b0;
			busy_ff  <= 1'b0;
			tmr_ff   <= 8'h00;
		end else begin
			scl_ff   <= {scl_ff[1:0], i_scl};
			sda_ff   <= {sda_ff[1:0], i_sda};
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			sr_ff    <= nxt_sr;
			tx_ff    <= nxt_tx;
			wbuf_ff  <= nxt_wbuf;
			ptr_ff   <= nxt_ptr;
			wvld_ff  <= nxt_wvld;
			oe_ff    <= nxt_oe;
			busy_ff  <= nxt_busy;
			tmr_ff   <= nxt_tmr;
		end
	end

	// Array is written only when the timed write cycle ends
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			mem_ff[ptr_ff] <= wbuf_ff;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	property p_nack_busy;
		busy_ff && state_ff == sep_pkg::SEP_CTRL && scl_fall &&
		cnt_ff == `SEP_BYTE_BITS |=> !o_sda_oe;
	endproperty
	a_nack_busy: assert property (p_nack_busy)
		else $error("ack given during write cycle");

	property p_ack_hit;
		!busy_ff && state_ff == sep_pkg::SEP_CTRL && scl_fall &&
		cnt_ff == `SEP_BYTE_BITS && code_hit && !start_cond && !stop_cond
		|=> o_sda_oe;
	endproperty
	a_ack_hit: assert property (p_ack_hit)
		else $error("matching control byte not acknowledged");

	property p_rw_sel;
		state_ff == sep_pkg::SEP_CTRL && scl_fall && !busy_ff && code_hit &&
		cnt_ff == `SEP_BYTE_BITS && !start_cond && !stop_cond
		|=> state_ff == ($past(sr_ff[0]) ? sep_pkg::SEP_ACK_RD
			: sep_pkg::SEP_ACK_CTRL);
	endproperty
	a_rw_sel: assert property (p_rw_sel)
		else $error("wrong operation for read/write bit");

	property p_addr_load;
		state_ff == sep_pkg::SEP_ADDR && scl_fall &&
		cnt_ff == `SEP_BYTE_BITS && !start_cond && !stop_cond
		|=> ptr_ff == $past(sr_ff[3:0]);
	endproperty
	a_addr_load: assert property (p_addr_load)
		else $error("pointer not loaded from word address");

	property p_commit;
		stop_cond && state_ff == sep_pkg::SEP_DATA && cnt_ff <= 4'h1 &&
		wvld_ff && !busy_ff |=> busy_ff && tmr_ff == WR_CYCLES;
	endproperty
	a_commit: assert property (p_commit)
		else $error("stop after data byte did not start write");

	property p_abort;
		stop_cond && !busy_ff && (state_ff != sep_pkg::SEP_DATA ||
		cnt_ff > 4'h1 || !wvld_ff) |=> !busy_ff;
	endproperty
	a_abort: assert property (p_abort)
		else $error("incomplete write launched a write cycle");

	property p_ptr_hold;
		busy_ff |=> ptr_ff == $past(ptr_ff);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("pointer moved during write cycle");

	property p_refill;
		state_ff == sep_pkg::SEP_DATA && scl_fall && !stop_cond &&
		!start_cond && cnt_ff == `SEP_BYTE_BITS |=> wbuf_ff == $past(sr_ff);
	endproperty
	a_refill: assert property (p_refill)
		else $error("data buffer not reloaded");

	property p_incr;
		fetch && fetch_ok |=> ptr_ff == $past(ptr_ff) + 4'h1;
	endproperty
	a_incr: assert property (p_incr)
		else $error("pointer did not step after read fetch");

	property p_release;
		state_ff == sep_pkg::SEP_MACK && scl_rise && sda_ff[1] &&
		!stop_cond && !start_cond |=> !o_sda_oe [*2];
	endproperty
	a_release: assert property (p_release)
		else $error("data line held after master nack");

	property p_start;
		start_cond && !stop_cond |=> state_ff == sep_pkg::SEP_CTRL &&
		!o_sda_oe;
	endproperty
	a_start: assert property (p_start)
		else $error("start not recognised");

	c_write: cover property (stop_cond && state_ff == sep_pkg::SEP_DATA &&
		wvld_ff && cnt_ff <= 4'h1);
	c_seq_read: cover property (state_ff == sep_pkg::SEP_MACK && scl_rise &&
		!sda_ff[1]);
	c_poll_nack: cover property (busy_ff && state_ff == sep_pkg::SEP_CTRL &&
		scl_fall && cnt_ff == `SEP_BYTE_BITS);

endmodule : sep_eeprom

/* File: rtl/sep_params.svh */
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// Control byte layout
`define SEP_DEV_CODE      4'hA
`define SEP_CODE_MSB      7
`define SEP_CODE_LSB      4
`define SEP_RW_BIT        0

// Byte framing
`define SEP_BYTE_BITS     4'h8

// Reset values, and the byte sent when the read buffer holds nothing
`define SEP_PTR_RST       4'h0
`define SEP_BYTE_RST      8'h00
`define SEP_IDLE_BYTE     8'hFF

// Internal write cycle timing
`define SEP_CLK_NS        40
`define SEP_WR_TIME_NS    4000
`define SEP_WR_CYCLES     (`SEP_WR_TIME_NS / `SEP_CLK_NS)

`endif

/* File: rtl/sep_pkg.sv */
package sep_pkg;

	typedef enum logic [3:0] {
		SEP_IDLE,
		SEP_CTRL,
		SEP_ACK_CTRL,
		SEP_ADDR,
		SEP_ACK_ADDR,
		SEP_DATA,
		SEP_ACK_DATA,
		SEP_ACK_RD,
		SEP_TX,
		SEP_MACK
	} sep_state_e;

	typedef logic [7:0] sep_byte_t;
	typedef logic [3:0] sep_addr_t;

endpackage : sep_pkg

/* File: verification/sep_eeprom_tb.sv */
module sep_eeprom_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam sep_pkg::sep_byte_t WR = 8'hA0;
	localparam sep_pkg::sep_byte_t RD = 8'hA1;

	logic clk;
	logic resetn;
	logic scl;
	logic pull;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic busy;
	int   n_fail;
	int   checked;

	// Open-drain wire with pull-up
	assign sda = (pull | sda_oe) ? 1'b0 : 1'b1;

	sep_eeprom i_dut (
		.i_clk     (clk),
		.i_resetn  (resetn),
		.i_scl     (scl),
		.i_sda     (sda),
		.o_sda_out (sda_out),
		.o_sda_oe  (sda_oe),
		.o_busy    (busy)
	);

	sep_master i_mst (
		.i_clk  (clk),
		.i_sda  (sda),
		.o_scl  (scl),
		.o_pull (pull)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic cmp8(input string nm, input sep_pkg::sep_byte_t e,
		input sep_pkg::sep_byte_t g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp8

	task automatic cmp1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp1

	task automatic close_out();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	task automatic ctl(input sep_pkg::sep_byte_t c, input logic e);
		logic a;
		i_mst.start();
		i_mst.wbyte(c, 8, a);
		cmp1("ctrl ack", e, a);
	endtask : ctl

	task automatic send(input sep_pkg::sep_byte_t b);
		logic a;
		i_mst.wbyte(b, 8, a);
		cmp1("byte ack", 1'b1, a);
	endtask : send

	// Polls at once after the launching stop
	task automatic poll();
		logic a;
		int   n;
		cmp1("busy", 1'b1, busy);
		n = 0;
		a = 1'b0;
		while (a !== 1'b1 && n < 30) begin
			i_mst.start();
			i_mst.wbyte(WR, 8, a);
			n++;
		end
		i_mst.stop();
		cmp1("poll ack", 1'b1, a);
		cmp1("nack while busy", 1'b1, n > 1);
	endtask : poll

	task automatic wr(input sep_pkg::sep_byte_t ad, sep_pkg::sep_byte_t d);
		ctl(WR, 1'b1);
		send(ad);
		send(d);
		i_mst.stop();
		poll();
	endtask : wr

	task automatic rd_rand(input sep_pkg::sep_byte_t ad,
		input sep_pkg::sep_byte_t e);
		sep_pkg::sep_byte_t b;
		ctl(WR, 1'b1);
		send(ad);
		ctl(RD, 1'b1);
		i_mst.rbyte(1'b0, b);
		i_mst.stop();
		cmp8("random read", e, b);
	endtask : rd_rand

	task automatic rd_cur(input sep_pkg::sep_byte_t e);
		sep_pkg::sep_byte_t b;
		ctl(RD, 1'b1);
		i_mst.rbyte(1'b0, b);
		cmp1("released", 1'b0, sda_oe);
		cmp1("drive value", 1'b0, sda_out);
		i_mst.stop();
		cmp8("current read", e, b);
	endtask : rd_cur

	task automatic t_basic();
		wr(8'hF3, 8'h5A);
		rd_cur(8'h5A);
		wr(8'h04, 8'hC3);
		rd_rand(8'h03, 8'h5A);
		rd_cur(8'hC3);
	endtask : t_basic

	task automatic t_seq();
		sep_pkg::sep_byte_t b;
		wr(8'h0F, 8'h81);
		wr(8'h00, 8'h7E);
		ctl(WR, 1'b1);
		send(8'h0F);
		ctl(RD, 1'b1);
		i_mst.rbyte(1'b1, b);
		cmp8("seq first", 8'h81, b);
		i_mst.rbyte(1'b0, b);
		i_mst.stop();
		cmp8("seq wrapped", 8'h7E, b);
	endtask : t_seq

	task automatic t_refuse();
		ctl(8'hB0, 1'b0);
		i_mst.stop();
		ctl(8'hAE, 1'b1);
		i_mst.stop();
	endtask : t_refuse

	task automatic t_abort();
		logic a;
		ctl(WR, 1'b1);
		send(8'h03);
		i_mst.stop();
		cmp1("busy no data", 1'b0, busy);
		ctl(WR, 1'b1);
		send(8'h03);
		send(8'h11);
		i_mst.wbyte(8'h22, 4, a);
		i_mst.stop();
		cmp1("busy partial", 1'b0, busy);
		rd_rand(8'h03, 8'h5A);
		ctl(WR, 1'b1);
		send(8'h03);
		send(8'h11);
		send(8'h66);
		i_mst.stop();
		poll();
		rd_rand(8'h03, 8'h66);
	endtask : t_abort

	initial begin
		n_fail  = 0;
		checked = 0;
		resetn  = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		t_basic();
		t_seq();
		t_refuse();
		t_abort();
		close_out();
	end

	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule : sep_eeprom_tb

/* File: verification/sep_master.sv */
module sep_master (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_pull
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_scl  = 1'b1;
		o_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask : tick

	// Start, or repeated start when the clock is low
	task automatic start();
		if (o_scl === 1'b0) begin
			tick(1);
			o_pull = 1'b0;
			tick(3);
			o_scl = 1'b1;
			tick(4);
		end
		o_pull = 1'b1;
		tick(4);
		o_scl = 1'b0;
	endtask : start

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		tick(1);
		o_pull = !b;
		tick(3);
		o_scl = 1'b1;
		tick(2);
		s = i_sda;
		tick(2);
		o_scl = 1'b0;
	endtask : bit_io

	// Released line goes high by the pull-up
	task automatic stop();
		tick(1);
		o_pull = 1'b1;
		tick(3);
		o_scl = 1'b1;
		tick(4);
		o_pull = 1'b0;
		tick(8);
	endtask : stop

	// Sends n bits MSB first, ack clock only for a full byte
	task automatic wbyte(input sep_pkg::sep_byte_t b, input int n,
		output logic ack);
		logic s;
		ack = 1'b0;
		for (int i = 0; i < n; i++) begin
			bit_io(b[7-i], s);
		end
		if (n == 8) begin
			bit_io(1'b1, s);
			ack = (s === 1'b0);
		end
	endtask : wbyte

	// Reads a byte, then acks or nacks it
	task automatic rbyte(input logic mack, output sep_pkg::sep_byte_t b);
		logic s;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, s);
			b[7-i] = s;
		end
		bit_io(!mack, s);
	endtask : rbyte
endmodule : sep_master
